// ==== hw/bpr_top.sv ====
// Purpose: Reporting stage of the beacon_transmission_module receive path
// Assumes: Decoder results and stamps come from logic on mclk_i
// Notes:   Field comparator output is asynchronous and synchronised here
`timescale 1ns/1ps
module bpr_top
    import bpr_pkg::*;
#(
    parameter int MIN_DET_CYC_P = MIN_DET_CYC,
    parameter int MS_CYC_P      = MS_CYC
) (
    // Clock and reset
    input  wire logic               mclk_i,
    input  wire logic               nrst_i,
    // Field comparator against receive_threshold (asynchronous)
    input  wire logic               field_above_i,
    // Decoder results
    input  wire logic               tel_valid_i,
    input  wire logic [TEL_W-1:0]   tel_data_i,
    input  wire logic               sidelobe_i,
    // Stamps and configuration
    input  wire logic [STAMP_W-1:0] time_i,
    input  wire logic [STAMP_W-1:0] odo_i,
    input  wire logic [PER_W-1:0]   period_ms_i,
    // Report to the train control core
    output logic                    rpt_valid_o,
    output logic [1:0]              rpt_kind_o,
    output logic                    rpt_has_tel_o,
    output logic [TEL_W-1:0]        rpt_data_o,
    output logic [STAMP_W-1:0]      rpt_refpos_o,
    output logic                    rpt_sidelobe_o,
    output logic [STAMP_W-1:0]      rpt_time_o,
    output logic [STAMP_W-1:0]      rpt_odo_o
);
    localparam int MSW = $clog2(MS_CYC_P);

    // ****************************************
    // Synchroniser and detection
    // ****************************************
    logic fld_s1_r;
    logic fld_s2_r;
    logic det_q;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fld_s1_r <= 1'b0;
            fld_s2_r <= 1'b0;
        end else begin
            fld_s1_r <= field_above_i;
            fld_s2_r <= fld_s1_r;
        end
    end

    bpr_qual #(
        .N      (MIN_DET_CYC_P)
    ) u_qual (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .lvl_i  (fld_s2_r),
        .qual_o (det_q)
    );

    // ****************************************
    // Decode of events
    // ****************************************
    bpr_state_t         state_r;
    bpr_state_t         state_nxt;
    logic               have_tel_r;
    logic [TEL_W-1:0]   data_r;
    logic [STAMP_W-1:0] odo_start_r;
    logic [MSW-1:0]     ms_cnt_r;
    logic [PER_W-1:0]   per_cnt_r;

    wire in_pass   = (state_r == BPR_PASS);
    wire start     = !in_pass && det_q;
    wire pass_end  = in_pass && !fld_s2_r;
    wire flat      = (tel_data_i == '0) || (tel_data_i == '1);
    // Telegrams only while field above threshold; first one kept
    wire tel_ok    = tel_valid_i && fld_s2_r && in_pass && !flat && !have_tel_r;
    // Clamp period into its legal range
    wire [PER_W-1:0] per_eff = (period_ms_i < PER_MIN_MS) ? PER_MIN_MS :
                               (period_ms_i > PER_MAX_MS) ? PER_MAX_MS : period_ms_i;
    wire ms_tick   = (ms_cnt_r == MSW'(MS_CYC_P - 1));
    wire per_hit   = (per_cnt_r == per_eff - 10'h001);
    wire tmo       = in_pass && fld_s2_r && ms_tick && per_hit;
    wire fire      = pass_end || tmo;
    // Midpoint of the passage as reference position
    wire [STAMP_W:0] mid_sum = {1'b0, odo_start_r} + {1'b0, odo_i};
    // At passage end, no telegram gives a detection report; a timeout always gives a preliminary one
    wire [1:0] kind_nxt = tmo ? KIND_PRELIM : (have_tel_r ? KIND_TEL : KIND_DETECT);
    // Final reference midpoint, preliminary uses start or side lobe
    wire [STAMP_W-1:0] ref_nxt = pass_end ? mid_sum[STAMP_W:1] : odo_start_r;

    assign state_nxt = start ? BPR_PASS : (pass_end ? BPR_IDLE : state_r);

    // ****************************************
    // Passage state
    // ****************************************
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r     <= BPR_IDLE;
            have_tel_r  <= 1'b0;
            data_r      <= '0;
            odo_start_r <= '0;
        end else begin
            state_r     <= state_nxt;
            have_tel_r  <= (start || pass_end) ? 1'b0 : (have_tel_r || tel_ok);
            data_r      <= start ? '0 : (tel_ok ? tel_data_i : data_r);
            odo_start_r <= start ? odo_i : odo_start_r;
        end
    end

    // ****************************************
    // Reporting period timer
    // ****************************************
    // Restart at start, clear after final report
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ms_cnt_r  <= '0;
            per_cnt_r <= '0;
        end else if (start || pass_end || !in_pass) begin
            ms_cnt_r  <= '0;
            per_cnt_r <= '0;
        end else begin
            ms_cnt_r  <= ms_tick ? '0 : ms_cnt_r + 1'b1;
            per_cnt_r <= !ms_tick ? per_cnt_r : (per_hit ? '0 : per_cnt_r + 10'h001);
        end
    end

    // ****************************************
    // Report outputs
    // ****************************************
    // Stamps taken in the reporting cycle
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rpt_valid_o    <= 1'b0;
            rpt_kind_o     <= KIND_NONE;
            rpt_has_tel_o  <= 1'b0;
            rpt_data_o     <= '0;
            rpt_refpos_o   <= '0;
            rpt_sidelobe_o <= 1'b0;
            rpt_time_o     <= '0;
            rpt_odo_o      <= '0;
        end else begin
            rpt_valid_o <= fire;
            if (fire) begin
                rpt_kind_o     <= kind_nxt;
                rpt_has_tel_o  <= have_tel_r;
                rpt_data_o     <= data_r;
                rpt_refpos_o   <= tmo && sidelobe_i ? odo_i : ref_nxt;
                rpt_sidelobe_o <= tmo && sidelobe_i;
                rpt_time_o     <= time_i;
                rpt_odo_o      <= odo_i;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    // Field high run length
    logic [31:0] hi_run_r;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_run_r <= '0;
        end else begin
            hi_run_r <= !fld_s2_r ? '0 : ((hi_run_r == '1) ? hi_run_r : hi_run_r + 32'h0000_0001);
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_end;
        in_pass && !fld_s2_r;
    endsequence
    sequence s_final;
        rpt_valid_o && (rpt_kind_o != KIND_PRELIM);
    endsequence

    a_final_on_end: assert property (s_end |=> s_final)
        else $error("no final report after passage end");
    a_single_final: assert property (s_final |-> !$past(in_pass) || !in_pass ##1 !rpt_valid_o)
        else $error("second report right after final report");
    a_detect_only: assert property (s_end ##0 !have_tel_r |=> rpt_kind_o == KIND_DETECT)
        else $error("detection without telegram not reported");
    a_flat_reject: assert property (tel_valid_i && flat && !have_tel_r |=> !have_tel_r)
        else $error("flat stream taken as telegram");
    a_prelim_tick: assert property (tmo |=> rpt_valid_o && rpt_kind_o == KIND_PRELIM)
        else $error("no preliminary report at timeout");
    a_period_range: assert property (per_eff >= PER_MIN_MS && per_eff <= PER_MAX_MS)
        else $error("period outside 50 to 600 ms");
    a_sidelobe_ref: assert property (tmo && sidelobe_i |=> rpt_sidelobe_o && rpt_refpos_o == $past(odo_i))
        else $error("side lobe reference not used");
    a_stamps: assert property (rpt_valid_o |-> rpt_time_o == $past(time_i) && rpt_odo_o == $past(odo_i))
        else $error("report stamps wrong");
    a_gate_low: assert property (tel_valid_i && !fld_s2_r && !have_tel_r |=> !have_tel_r)
        else $error("telegram taken below threshold");
    a_min_detect: assert property ($rose(det_q) |-> hi_run_r >= 32'(MIN_DET_CYC_P))
        else $error("detection before minimum time");
    a_timer_restart: assert property (start ##1 fld_s2_r |-> per_cnt_r == '0 && ms_cnt_r == '0 ##1 ms_cnt_r == MSW'(1))
        else $error("period timer not restarted");
    a_timer_clear: assert property (s_end |=> per_cnt_r == '0 && ms_cnt_r == '0)
        else $error("period timer not cleared after final report");
    a_prelim_data: assert property (tmo |=> rpt_has_tel_o == $past(have_tel_r) && rpt_data_o == $past(data_r))
        else $error("preliminary report lost the telegram");
endmodule : bpr_top

// ==== hw/bpr_pkg.sv ====
// Purpose: Shared constants and types for the beacon passage reporter
// Assumes: 100 MHz receiver clock
// Notes:   Period limits in milliseconds, detection time in microseconds
package bpr_pkg;
    // ****************************************
    // Widths and clock
    // ****************************************
    localparam int TEL_W        = 32;
    localparam int STAMP_W      = 32;
    localparam int PER_W        = 10;
    localparam int CLK_MHZ      = 100;
    // ****************************************
    // Timing
    // ****************************************
    localparam int MIN_DET_US   = 100;
    localparam int MIN_DET_CYC  = MIN_DET_US * CLK_MHZ;
    localparam int MS_US        = 1000;
    localparam int MS_CYC       = MS_US * CLK_MHZ;
    localparam logic [PER_W-1:0] PER_MIN_MS = 10'h032;
    localparam logic [PER_W-1:0] PER_MAX_MS = 10'h258;
    // ****************************************
    // Report kinds
    // ****************************************
    localparam logic [1:0] KIND_NONE    = 2'h0;
    localparam logic [1:0] KIND_DETECT  = 2'h1;
    localparam logic [1:0] KIND_TEL     = 2'h2;
    localparam logic [1:0] KIND_PRELIM  = 2'h3;
    typedef enum logic {BPR_IDLE, BPR_PASS} bpr_state_t;
endpackage : bpr_pkg

// ==== hw/bpr_qual.sv ====
// Purpose: Qualifies a level that must stay high for N cycles
// Assumes: lvl_i already synchronous to mclk_i
// Notes:   Output drops in the cycle after the level falls
`timescale 1ns/1ps
module bpr_qual #(
    parameter int N = 16
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    // Level in, qualified level out
    input  wire logic lvl_i,
    output logic      qual_o
);
    localparam int CW = $clog2(N + 1);
    logic [CW-1:0] cnt_r;
    wire           at_end = (cnt_r >= CW'(N - 1));

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r  <= '0;
            qual_o <= 1'b0;
        end else begin
            cnt_r  <= !lvl_i ? '0 : (at_end ? cnt_r : cnt_r + 1'b1);
            qual_o <= lvl_i && at_end;
        end
    end
endmodule : bpr_qual

// ==== sim/bpr_core_model.sv ====
// Purpose: Train control core side, consumes beacon reports
// Assumes: Report strobe is a one-cycle pulse on mclk_i
// Notes:   Counts reports and notes the cycle of the latest one
`timescale 1ns/1ps
module bpr_core_model (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    // Report strobe
    input  wire logic rpt_valid_i,
    // Report bookkeeping
    output int        rpt_cnt_o,
    output int        cyc_o,
    output int        last_cyc_o
);
    // ****************************************
    // Report capture
    // ****************************************
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rpt_cnt_o  <= 0;
            cyc_o      <= 0;
            last_cyc_o <= 0;
        end else begin
            cyc_o <= cyc_o + 1;
            if (rpt_valid_i === 1'b1) begin
                rpt_cnt_o  <= rpt_cnt_o + 1;
                last_cyc_o <= cyc_o;
            end
        end
    end
endmodule : bpr_core_model

// ==== sim/test_balise_passage_reporter.sv ====
// Purpose: Self-checking bench for the beacon passage reporter
// Assumes: Short detection and millisecond counts via parameters
// Notes:   One period is per_eff times MS_P cycles
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module test_balise_passage_reporter
    import bpr_pkg::*;
;
    localparam int DET_P = 4;
    localparam int MS_P  = 10;
    logic mclk_i = 0, nrst_i = 0, field_above_i = 0, tel_valid_i = 0, sidelobe_i = 0;
    logic [TEL_W-1:0] tel_data_i = '0;
    logic [STAMP_W-1:0] time_i = '0, odo_i = '0;
    logic [PER_W-1:0] period_ms_i = 10'h032;
    logic rpt_valid_o, rpt_has_tel_o, rpt_sidelobe_o;
    logic [1:0] rpt_kind_o;
    logic [TEL_W-1:0] rpt_data_o;
    logic [STAMP_W-1:0] rpt_refpos_o, rpt_time_o, rpt_odo_o;
    int rpt_cnt, cyc, last_cyc, errors = 0, num_checks = 0;
    always #5 mclk_i = ~mclk_i;
    bpr_top #(.MIN_DET_CYC_P(DET_P), .MS_CYC_P(MS_P)) bpr_top_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .field_above_i(field_above_i), .tel_valid_i(tel_valid_i), .tel_data_i(tel_data_i),
        .sidelobe_i(sidelobe_i), .time_i(time_i), .odo_i(odo_i), .period_ms_i(period_ms_i),
        .rpt_valid_o(rpt_valid_o), .rpt_kind_o(rpt_kind_o), .rpt_has_tel_o(rpt_has_tel_o),
        .rpt_data_o(rpt_data_o), .rpt_refpos_o(rpt_refpos_o), .rpt_sidelobe_o(rpt_sidelobe_o),
        .rpt_time_o(rpt_time_o), .rpt_odo_o(rpt_odo_o));
    bpr_core_model bpr_core_model_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .rpt_valid_i(rpt_valid_o),
        .rpt_cnt_o(rpt_cnt), .cyc_o(cyc), .last_cyc_o(last_cyc));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic wait_rpt(input int limit);
        int n0;
        n0 = rpt_cnt;
        for (int i = 0; i < limit && rpt_cnt == n0; i++) tick(1);
        `CHK("report arrived", 1'b1, rpt_cnt != n0)
    endtask : wait_rpt
    // One idle edge after the pulse keeps back-to-back calls apart
    task automatic pulse_tel(input logic [TEL_W-1:0] d);
        tel_data_i = d;
        tel_valid_i = 1'b1;
        tick(1);
        tel_valid_i = 1'b0;
        tick(1);
    endtask : pulse_tel
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_pass_tel();
        int n0;
        odo_i = 32'h0000_0064;
        time_i = 32'h0000_0007;
        field_above_i = 1'b1;
        tick(10);
        n0 = rpt_cnt;
        pulse_tel(32'h1234_5678);
        pulse_tel(32'hcafe_0001);
        odo_i = 32'h0000_00c8;
        time_i = 32'h0000_0009;
        tick(2);
        field_above_i = 1'b0;
        wait_rpt(10);
        tick(5);
        `CHK("one report", n0 + 1, rpt_cnt)
        `CHK("kind", KIND_TEL, rpt_kind_o)
        `CHK("has tel", 1'b1, rpt_has_tel_o)
        `CHK("data", 32'h1234_5678, rpt_data_o)
        `CHK("refpos", 32'h0000_0096, rpt_refpos_o)
        `CHK("time", 32'h0000_0009, rpt_time_o)
        `CHK("odo", 32'h0000_00c8, rpt_odo_o)
    endtask : t_pass_tel
    task automatic t_flat();
        pulse_tel(32'h0f0f_0f0f);
        field_above_i = 1'b1;
        tick(10);
        pulse_tel(32'hffff_ffff);
        pulse_tel(32'h0000_0000);
        field_above_i = 1'b0;
        wait_rpt(10);
        `CHK("kind", KIND_DETECT, rpt_kind_o)
        `CHK("has tel", 1'b0, rpt_has_tel_o)
        `CHK("data", 32'h0000_0000, rpt_data_o)
    endtask : t_flat
    task automatic t_blip();
        int n0;
        n0 = rpt_cnt;
        field_above_i = 1'b1;
        tick(3);
        field_above_i = 1'b0;
        tick(30);
        `CHK("no report", n0, rpt_cnt)
    endtask : t_blip
    task automatic t_prelim(input logic [PER_W-1:0] per, input int per_cyc, input logic with_tel);
        int c0, c1;
        period_ms_i = per;
        sidelobe_i = 1'b0;
        odo_i = 32'h0000_012c;
        field_above_i = 1'b1;
        c0 = cyc;
        if (with_tel) begin
            tick(10);
            pulse_tel(32'h5a5a_0001);
        end
        wait_rpt(per_cyc + 40);
        c1 = last_cyc;
        `CHK("first timeout", 1'b1, (c1 - c0) >= per_cyc && (c1 - c0) <= per_cyc + 12)
        `CHK("kind", KIND_PRELIM, rpt_kind_o)
        `CHK("refpos", 32'h0000_012c, rpt_refpos_o)
        `CHK("sidelobe", 1'b0, rpt_sidelobe_o)
        `CHK("prelim has tel", with_tel, rpt_has_tel_o)
        `CHK("prelim data", with_tel ? 32'h5a5a_0001 : 32'h0000_0000, rpt_data_o)
        sidelobe_i = 1'b1;
        odo_i = 32'h0000_0190;
        wait_rpt(per_cyc + 40);
        `CHK("repeat", per_cyc, last_cyc - c1)
        `CHK("kind", KIND_PRELIM, rpt_kind_o)
        `CHK("sidelobe", 1'b1, rpt_sidelobe_o)
        `CHK("refpos", 32'h0000_0190, rpt_refpos_o)
        sidelobe_i = 1'b0;
        field_above_i = 1'b0;
        wait_rpt(10);
        `CHK("final kind", with_tel ? KIND_TEL : KIND_DETECT, rpt_kind_o)
        `CHK("final data", with_tel ? 32'h5a5a_0001 : 32'h0000_0000, rpt_data_o)
        tick(5);
    endtask : t_prelim
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        tick(20);
        nrst_i = 1'b1;
        tick(2);
        `CHK("idle valid", 1'b0, rpt_valid_o)
        t_pass_tel();
        t_flat();
        t_blip();
        // Below the lower limit, so 50 ms applies
        t_prelim(10'h00a, 50 * MS_P, 1'b0);
        // Inside the legal range, with a telegram captured first
        t_prelim(10'h064, 100 * MS_P, 1'b1);
        // Above the upper limit, so 600 ms applies
        t_prelim(10'h3ff, 600 * MS_P, 1'b0);
        t_pass_tel();
        conclude();
    end
    initial begin
        #400000;
        errors++;
        conclude();
    end
endmodule : test_balise_passage_reporter
